// [design/nmp_pkg.sv]
// Purpose: Constants and types for the namespace metadata and protection
//          capability register bank.
// Assumes: AHB-Lite register access, 32-bit data, one register per word.
// Notes:   Register indices are word positions; byte address is index * 4.
package nmp_pkg;
    // Register indices; the bus address is the index shifted left by two.
    localparam logic [7:0] IDX_ACTIVE_FORMAT = 8'h1A;
    localparam logic [7:0] IDX_MD_CAPS       = 8'h1B;
    localparam logic [7:0] IDX_PROT_CAPS     = 8'h1C;
    localparam logic [7:0] IDX_PROT_SETTINGS = 8'h1D;
    localparam logic [7:0] IDX_CAP_CONFIG    = 8'h40;
    localparam logic [7:0] IDX_SET_REQUEST   = 8'h41;
    localparam logic [7:0] IDX_STATUS        = 8'h42;
    localparam int         IDX_LSB           = 2;
    localparam int         IDX_MSB           = 9;

    // Metadata capability byte fields.
    localparam int MC_EXTENDED  = 0;
    localparam int MC_SEPARATE  = 1;
    // Protection capability byte fields.
    localparam int DPC_TYPE1    = 0;
    localparam int DPC_TYPE2    = 1;
    localparam int DPC_TYPE3    = 2;
    localparam int DPC_FIRST8   = 3;
    localparam int DPC_LAST8    = 4;
    // Protection setting byte and active format fields.
    localparam int DPS_FIRST8   = 3;
    localparam int FMT_EXTENDED = 4;
    // Capability configuration word: metadata caps low, protection caps high.
    localparam int CFG_DPC_LSB  = 8;
    // Status bits.
    localparam int ST_SET_REJ   = 0;
    localparam int ST_FMT_REJ   = 1;
    localparam int ST_CAP_REJ   = 2;

    localparam logic [2:0] PI_DISABLED = 3'h0;
    localparam logic [2:0] PI_TYPE1    = 3'h1;
    localparam logic [2:0] PI_TYPE2    = 3'h2;
    localparam logic [2:0] PI_TYPE3    = 3'h3;

    localparam logic [1:0] RST_MC  = 2'h2;
    localparam logic [4:0] RST_DPC = 5'h00;
    localparam logic [4:0] RST_FMT = 5'h00;
    localparam logic [3:0] RST_DPS = 4'h0;

    typedef struct packed {
        logic [1:0]  mc;
        logic [4:0]  protection_capabilities;
        logic [4:0]  fmt;
        logic [3:0]  protection_type_settings;
        logic [2:0]  rej;
        logic        ph_val;
        logic        ph_wr;
        logic [7:0]  ph_idx;
        logic [31:0] rdata;
        logic        rdy;
    } nmp_state_t;
endpackage : nmp_pkg

// [design/nmp_caps.sv]
// Purpose: Namespace metadata and protection capability register bank
//          behind an AHB-Lite slave.
// Assumes: Single word transfers only; one clock, synchronous reset.
// Notes:   Function
// Function
// [R1] Metadata capability byte at index 27; bit 1 flags separate buffer.
// [R2] Metadata capability bit 0 flags metadata inside extended blocks.
// [R3] Metadata capability bits 7:2 read as zero.
// [R4] Protection capability byte at index 28; several bits may be set.
// [R5] Protection capability bit 4 flags information in last eight bytes.
// [R6] Protection capability bit 3 flags information in first eight bytes.
// [R7] Protection capability bits 2,1,0 flag types 3,2,1 independently.
// [R8] Protection capability bits 7:5 read as zero.
// [R9] Setting byte at index 29; bit 3 set means first eight bytes.
// [R10] Setting bits 2:0: 0 off, 1..3 type 1..3, 4..7 reserved.
// [R11] Setting bits 7:4 read as zero.
// [R12] Active format bit 4 one means extended blocks, zero separate buffer.
// [R13] Metadata travels wholly extended or wholly separate, never split.
// [R14] Reported setting is only ever one the capabilities advertise.
`timescale 1ns/1ps
module nmp_caps (
    input  wire logic        clock,     // 200 MHz clock
    input  wire logic        rstn,      // synchronous reset, active low
    input  wire logic        hsel,      // slave select
    input  wire logic [31:0] haddr,     // byte address
    input  wire logic [1:0]  htrans,    // transfer type
    input  wire logic        hwrite,    // write when high
    input  wire logic [2:0]  hsize,     // transfer size, word only
    input  wire logic [31:0] hwdata,    // write data
    input  wire logic        hready,    // bus ready
    output logic             hreadyout, // slave ready
    output logic             hresp,     // response, always OKAY
    output logic [31:0]      hrdata,    // read data
    output logic             md_extended, // metadata in extended blocks
    output logic             md_separate, // metadata in separate buffer
    output logic [2:0]       pi_type,   // active protection type code
    output logic             pi_first8  // protection in first eight bytes
);
    nmp_pkg::nmp_state_t s_q;
    nmp_pkg::nmp_state_t s_d;

    // A placement is legal only when the capability byte offers it.
    function automatic logic fmt_ok(input logic [4:0] fmt,
                                    input logic [1:0] mc);
        if (fmt[nmp_pkg::FMT_EXTENDED]) begin
            fmt_ok = mc[nmp_pkg::MC_EXTENDED]; // [R13]
        end else begin
            fmt_ok = mc[nmp_pkg::MC_SEPARATE]; // [R13]
        end
    endfunction : fmt_ok

    // A setting is legal when disabled, or when its type and placement are both offered.
    function automatic logic dps_ok(input logic [3:0] protection_type_settings,
                                    input logic [4:0] protection_capabilities);
        logic place;
        place = protection_type_settings[nmp_pkg::DPS_FIRST8] ? protection_capabilities[nmp_pkg::DPC_FIRST8]
                                         : protection_capabilities[nmp_pkg::DPC_LAST8];
        case (protection_type_settings[2:0])
            nmp_pkg::PI_DISABLED: dps_ok = 1'b1;
            nmp_pkg::PI_TYPE1:    dps_ok = protection_capabilities[nmp_pkg::DPC_TYPE1] & place;
            nmp_pkg::PI_TYPE2:    dps_ok = protection_capabilities[nmp_pkg::DPC_TYPE2] & place;
            nmp_pkg::PI_TYPE3:    dps_ok = protection_capabilities[nmp_pkg::DPC_TYPE3] & place;
            default:              dps_ok = 1'b0; // [R10]
        endcase
    endfunction : dps_ok

    always_comb begin
        s_d     = s_q;
        s_d.rdy = 1'b1;

        // Data phase of a write.
        if (s_q.ph_val && s_q.ph_wr) begin
            case (s_q.ph_idx)
                nmp_pkg::IDX_CAP_CONFIG: begin
                    // A namespace with no metadata path at all would leave
                    // placement undefined, so such a write is refused.
                    if (hwdata[1:0] == 2'h0) begin
                        s_d.rej[nmp_pkg::ST_CAP_REJ] = 1'b1;
                    end else begin
                        s_d.rej[nmp_pkg::ST_CAP_REJ] = 1'b0;
                        s_d.mc  = hwdata[1:0];                       // [R1]
                        s_d.protection_capabilities = hwdata[nmp_pkg::CFG_DPC_LSB +: 5]; // [R4]
                        // Revalidate the active choices against new caps.
                        if (!fmt_ok(s_d.fmt, s_d.mc)) begin
                            s_d.fmt[nmp_pkg::FMT_EXTENDED] =
                                ~s_d.fmt[nmp_pkg::FMT_EXTENDED]; // [R13]
                        end
                        if (!dps_ok(s_d.protection_type_settings, s_d.protection_capabilities)) begin
                            s_d.protection_type_settings = {1'b0, nmp_pkg::PI_DISABLED}; // [R14]
                        end
                    end
                end
                nmp_pkg::IDX_ACTIVE_FORMAT: begin
                    if (fmt_ok(hwdata[4:0], s_q.mc)) begin
                        s_d.fmt = hwdata[4:0]; // [R12]
                        s_d.rej[nmp_pkg::ST_FMT_REJ] = 1'b0;
                    end else begin
                        s_d.rej[nmp_pkg::ST_FMT_REJ] = 1'b1;
                    end
                end
                nmp_pkg::IDX_SET_REQUEST: begin
                    if (dps_ok(hwdata[3:0], s_q.protection_capabilities)) begin
                        s_d.protection_type_settings = hwdata[3:0]; // [R14]
                        s_d.rej[nmp_pkg::ST_SET_REJ] = 1'b0;
                    end else begin
                        s_d.rej[nmp_pkg::ST_SET_REJ] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Address phase; read data is staged so it stands in the data phase.
        s_d.ph_val = 1'b0;
        s_d.ph_wr  = 1'b0;
        s_d.rdata  = 32'h0000_0000;
        if (hsel && htrans[1] && hready) begin
            s_d.ph_val = 1'b1;
            s_d.ph_wr  = hwrite;
            s_d.ph_idx = haddr[nmp_pkg::IDX_MSB:nmp_pkg::IDX_LSB];
            if (!hwrite) begin
                case (haddr[nmp_pkg::IDX_MSB:nmp_pkg::IDX_LSB])
                    nmp_pkg::IDX_ACTIVE_FORMAT:
                        s_d.rdata = {27'h0, s_d.fmt};
                    nmp_pkg::IDX_MD_CAPS:
                        s_d.rdata = {30'h0, s_d.mc};       // [R1] [R2] [R3]
                    nmp_pkg::IDX_PROT_CAPS:
                        s_d.rdata = {27'h0, s_d.protection_capabilities}; // [R5] [R6] [R7] [R8]
                    nmp_pkg::IDX_PROT_SETTINGS:
                        s_d.rdata = {28'h0, s_d.protection_type_settings};      // [R9] [R11]
                    nmp_pkg::IDX_CAP_CONFIG:
                        s_d.rdata = {19'h0, s_d.protection_capabilities, 6'h00, s_d.mc};
                    nmp_pkg::IDX_SET_REQUEST:
                        s_d.rdata = {28'h0, s_d.protection_type_settings};
                    nmp_pkg::IDX_STATUS:
                        s_d.rdata = {29'h0, s_d.rej};
                    default:
                        s_d.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_q        <= '0;
            s_q.mc     <= nmp_pkg::RST_MC;
            s_q.protection_capabilities    <= nmp_pkg::RST_DPC;
            s_q.fmt    <= nmp_pkg::RST_FMT;
            s_q.protection_type_settings    <= nmp_pkg::RST_DPS;
            s_q.rdy    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout   = s_q.rdy;
    assign hresp       = 1'b0;
    assign hrdata      = s_q.rdata;
    assign md_extended = s_q.fmt[nmp_pkg::FMT_EXTENDED];  // [R12]
    assign md_separate = ~s_q.fmt[nmp_pkg::FMT_EXTENDED]; // [R13]
    assign pi_type     = s_q.protection_type_settings[2:0];                    // [R10]
    assign pi_first8   = s_q.protection_type_settings[nmp_pkg::DPS_FIRST8];    // [R9]
endmodule : nmp_caps

// [verif/nmp_caps_properties.sv]
// Purpose: Port-level assertions for the capability register bank.
// Assumes: Zero wait states; a read answers in the following data phase.
// Notes:   Bodies other than p_rsv_req are kept on one line each to stay within the size budget.
`timescale 1ns/1ps
module nmp_caps_props (
    input wire logic        clock,       // clock
    input wire logic        rstn,        // reset
    input wire logic        hsel,        // select
    input wire logic [31:0] haddr,       // address
    input wire logic [1:0]  htrans,      // type
    input wire logic        hwrite,      // write
    input wire logic [31:0] hwdata,      // wdata
    input wire logic        hready,      // ready
    input wire logic [31:0] hrdata,      // rdata
    input wire logic        md_extended, // extended
    input wire logic        md_separate, // separate
    input wire logic [2:0]  pi_type,     // type code
    input wire logic        pi_first8    // placement
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence s_tk(w, logic [7:0] i);
        hsel && htrans[1] && hready && hwrite == w && haddr[9:2] == i;
    endsequence
    property p_mc_rsv; s_tk(1'b0, 8'h1B) |=> hrdata[31:2] == '0; endproperty
    a_mc_rsv: assert property (p_mc_rsv) else $error("mc high bits");
    property p_dc_rsv; s_tk(1'b0, 8'h1C) |=> hrdata[31:5] == '0; endproperty
    a_dc_rsv: assert property (p_dc_rsv) else $error("pc high bits");
    property p_ds_rsv; s_tk(1'b0, 8'h1D) |=> hrdata[31:4] == '0; endproperty
    a_ds_rsv: assert property (p_ds_rsv) else $error("ps high bits");
    property p_ds_view;
        s_tk(1'b0, 8'h1D) |=> hrdata[3:0] == {pi_first8, pi_type}; endproperty
    a_ds_view: assert property (p_ds_view) else $error("ps view");
    property p_fm_view;
        s_tk(1'b0, 8'h1A) |=> hrdata[4] == md_extended; endproperty
    a_fm_view: assert property (p_fm_view) else $error("format view");
    property p_split; md_separate != md_extended; endproperty
    a_split: assert property (p_split) else $error("metadata split");
    property p_code; pi_type[2] == 1'b0; endproperty
    a_code: assert property (p_code) else $error("reserved type code");
    property p_rsv_req; s_tk(1'b1, 8'h41) ##1 hwdata[2]
        |=> $stable(pi_type) && $stable(pi_first8); endproperty
    a_rsv_req: assert property (p_rsv_req) else $error("reserved taken");
endmodule : nmp_caps_props
bind nmp_caps nmp_caps_props nmp_caps_props_inst (.clock(clock), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .md_extended(md_extended), .md_separate(md_separate),
    .pi_type(pi_type), .pi_first8(pi_first8));

// [verif/test_nmp_caps.sv]
// Purpose: Self-checking bench for the capability register bank.
// Assumes: One slave, so its ready output is fed back as the bus ready.
// Notes:   Status bits track the last attempt of each kind, not history.
`timescale 1ns/1ps
module test_nmp_caps;
    logic        clock = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2, pi_type;
    logic        hreadyout, hresp, md_extended, md_separate, pi_first8;
    int          err_total = 0, total_checks = 0;
    nmp_caps nmp_caps_inst (.clock(clock), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .md_extended(md_extended),
        .md_separate(md_separate), .pi_type(pi_type), .pi_first8(pi_first8));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // A bounded wait keeps a stuck slave from hanging the run.
    task automatic wait_rdy;
        for (int n = 0; n < 20; n++) begin
            @(posedge clock);
            if (hreadyout === 1'b1) return;
        end
        err_total++;
        end_of_test();
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [31:0] a, d);
        hwrite <= w;
        haddr <= a;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic rdc(input string n, input logic [31:0] a, e);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        hsel <= 1'b1;
        rdc("md caps", 32'h6C, 32'h2);
        rdc("prot caps", 32'h70, 32'h0);
        rdc("setting", 32'h74, 32'h0);
        chk("lanes", 32'h1, {30'h0, md_extended, md_separate});
        chk("resp", 32'h0, {31'h0, hresp});
        $display("test reset done");
        xfer(1'b1, 32'h100, 32'hFFFFFFFF);
        rdc("md caps", 32'h6C, 32'h3);
        rdc("prot caps", 32'h70, 32'h1F);
        xfer(1'b1, 32'h6C, 32'h0);
        rdc("md caps", 32'h6C, 32'h3);
        for (int t = 1; t < 4; t++) begin
            xfer(1'b1, 32'h104, 32'h8 | t);
            rdc("setting", 32'h74, 32'h8 | t);
            chk("pi", 32'h8 | t, {28'h0, pi_first8, pi_type});
        end
        xfer(1'b1, 32'h104, 32'hF2);
        rdc("setting", 32'h74, 32'h2);
        xfer(1'b1, 32'h104, 32'h5);
        rdc("setting", 32'h74, 32'h2);
        rdc("status", 32'h108, 32'h1);
        $display("test codes done");
        xfer(1'b1, 32'h68, 32'h10);
        rdc("format", 32'h68, 32'h10);
        chk("lanes", 32'h2, {30'h0, md_extended, md_separate});
        xfer(1'b1, 32'h100, 32'h902);
        rdc("format", 32'h68, 32'h0);
        rdc("setting", 32'h74, 32'h0);
        xfer(1'b1, 32'h68, 32'h10);
        rdc("status", 32'h108, 32'h3);
        xfer(1'b1, 32'h104, 32'h3);
        xfer(1'b1, 32'h104, 32'h1);
        rdc("setting", 32'h74, 32'h0);
        xfer(1'b1, 32'h104, 32'h9);
        rdc("setting", 32'h74, 32'h9);
        $display("test support done");
        xfer(1'b1, 32'h100, 32'h0);
        rdc("md caps", 32'h6C, 32'h2);
        rdc("status", 32'h108, 32'h6);
        xfer(1'b1, 32'h200, 32'hFFFFFFFF);
        rdc("unmapped", 32'h200, 32'h0);
        $display("test refusals done");
        end_of_test();
    end
endmodule : test_nmp_caps
